// >>> ats_pkg.sv
/*
 * Shared constants for the timer-triggered conversion sequencer: register
 * offsets, field positions, reset values and counter limits.
 * Assumes a byte-addressed register port with one aligned word per register.
 */
`default_nettype none

package ats_pkg;
   // Port widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int RES_W = 10;

   // Register offsets
   localparam logic [7:0] OFS_CONVERTER_MODE_REG0 = 8'h00;
   localparam logic [7:0] OFS_CONVERTER_MODE_REG1 = 8'h04;
   localparam logic [7:0] OFS_TIMER_CONTROL_REG_A = 8'h08;
   localparam logic [7:0] OFS_TIMER_CONTROL_REG_B = 8'h0c;
   localparam logic [7:0] OFS_TIMER_STRIDE = 8'h08;
   localparam logic [7:0] OFS_COMPARE_REG_BASE = 8'h18;
   localparam logic [7:0] OFS_CONV_RESULT_REG_BASE = 8'h40;
   localparam logic [7:0] OFS_CONV_RESULT_REG_END = 8'h60;

   // Field positions of converter_mode_reg0
   localparam int M0_ENABLE_BIT = 7;
   localparam int M0_STATUS_BIT = 6;
   localparam int M0_FOURBUF_BIT = 5;
   localparam int M0_SELECT_BIT = 4;
   localparam int M0_CHAN_LSB = 0;
   // Field positions of converter_mode_reg1 and timer controls
   localparam int M1_FOURTRIG_BIT = 0;
   localparam int TC_A_ENABLE_BIT = 0;
   localparam int TC_B_OSTOP_BIT = 0;

   // Reset values, counter limits and scan channel bounds
   localparam logic [2:0] CHAN_RST = 3'h0;
   localparam logic [15:0] COMPARE_RST = 16'h0000;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [1:0] LAST_LOWER = 2'h3;
   localparam logic [2:0] FIRST_UPPER = 3'h4;
endpackage : ats_pkg

`default_nettype wire

// >>> ats_timer.sv
/*
 * One 16-bit compare timer with two compare units, as seen by the sequencer.
 * Assumes enable writes arrive as one-cycle strobes from the register port.
 */
`default_nettype none

module ats_timer import ats_pkg::*; (
   input wire logic mclk,
   input wire logic reset,
   input wire logic enable_wr,
   input wire logic enable_val,
   input wire logic overflow_stop,
   input wire logic [15:0] compare_a,
   input wire logic [15:0] compare_b,
   output logic running,
   output logic [15:0] count,
   output logic match_a,
   output logic match_b
);
   logic at_max;

   assign at_max = (count == COUNT_MAX);

   // Match pulses only while counting; count moves every cycle so each is one cycle
   assign match_a = running && (count == compare_a); // RL24
   assign match_b = running && (count == compare_b); // RL24

   // Run flag: set by software, dropped on overflow in one-shot mode
   always_ff @(posedge mclk) begin
      if (reset) begin
         running <= 1'b0;
      end else if (enable_wr) begin
         running <= enable_val; // RL2
      end else if (running && at_max && overflow_stop) begin
         running <= 1'b0; // RL1
      end
   end

   // Counter: an enable write restarts it from zero, wraps in loop mode
   always_ff @(posedge mclk) begin
      if (reset) begin
         count <= COUNT_ZERO;
      end else if (enable_wr) begin
         count <= COUNT_ZERO; // RL2
      end else if (running) begin
         count <= at_max ? COUNT_ZERO : count + 16'h0001; // RL1 RL3
      end
   end

   a_overflow_hold: assert property (@(posedge mclk) disable iff (reset) // RL1
      running && at_max && overflow_stop && !enable_wr |=> !running && count == 16'h0000 ##1 count == 16'h0000)
      else $error("one-shot timer did not stop at zero");
   a_overflow_wrap: assert property (@(posedge mclk) disable iff (reset) // RL3
      running && at_max && !overflow_stop && !enable_wr |=> running && count == 16'h0000)
      else $error("loop timer did not wrap");
   a_restart_runs: assert property (@(posedge mclk) disable iff (reset) // RL2
      enable_wr && enable_val |=> running && count == 16'h0000 ##1 (running || $past(at_max) || $past(enable_wr)))
      else $error("timer did not resume after enable write");
   a_stopped_silent: assert property (@(posedge mclk) disable iff (reset) // RL1
      !running |-> !match_a && !match_b)
      else $error("stopped timer issued a match");
endmodule : ats_timer

`default_nettype wire

// >>> ats_result_mem.sv
/*
 * Eight conversion result words with one write port and a registered read.
 * Assumes write and read addresses are already decoded to an entry index.
 */
`default_nettype none

module ats_result_mem import ats_pkg::*; (
   input wire logic mclk,
   input wire logic reset,
   input wire logic wr_en,
   input wire logic [2:0] wr_addr,
   input wire logic [RES_W-1:0] wr_data,
   input wire logic [2:0] rd_addr,
   output logic [RES_W-1:0] rd_data
);
   logic [RES_W-1:0] entry [8];

   // Storage; an entry keeps its value until overwritten
   always_ff @(posedge mclk) begin
      if (reset) begin
         for (int i = 0; i < 8; i++) begin
            entry[i] <= '0;
         end
      end else if (wr_en) begin
         entry[wr_addr] <= wr_data;
      end
   end

   // Registered read port
   always_ff @(posedge mclk) begin
      if (reset) begin
         rd_data <= '0;
      end else begin
         rd_data <= entry[rd_addr];
      end
   end
endmodule : ats_result_mem

`default_nettype wire

// >>> ats_sequencer.sv
/*
 * Timer-triggered conversion sequencer: two compare timers, mode registers,
 * trigger selection, result steering and conversion-end signalling.
 * Assumes a converter core that converts on conv_start, answers conv_done with
 * conv_data some cycles later and drops the job on conv_abort.
 */
// The register offsets and the strobed register port are this design's own decisions.
`default_nettype none

// What this block does
// RL1 - One-shot overflow holds zero, stops matching
// RL2 - Writing count enable restarts stopped timer
// RL3 - Loop mode wraps and keeps triggering
// RL4 - Select mode converts one channel 0-3
// RL5 - Each match 00 converts, ends, clears flag
// RL6 - One-shot single conversion; restart via timer
// RL7 - Loop mode repeats while converter enabled
// RL8 - Any of four matches, same result register
// RL9 - First match after restart sets flag
// RL10 - Any trigger order, repeats accepted
// RL11 - Four match 00 events fill results 0-3
// RL12 - Fewer than four: no end, standby
// RL13 - Match source picks result register
// RL14 - Scan ascends from channel 0, lower first
// RL15 - Upper channels converted back to back
// RL16 - Scan advances one lower channel per match
// RL17 - Match after completion restarts the scan
// RL18 - Short scan raises no end event
// RL19 - Four-trigger scan: source selects channel
// RL20 - Loop scan restarts on next match
// RL21 - Enable bit puts block in trigger standby
// RL22 - Clearing enable aborts, no result stored
// RL23 - Mode write aborts, result discarded
// RL24 - Matches arrive as single-cycle pulses
// RL25 - Counts cleared on finish, restart, abort
module ats_sequencer import ats_pkg::*; (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic [DATA_W-1:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [DATA_W-1:0] bus_rdata,
   output logic conv_start,
   output logic [2:0] conv_chan,
   output logic conv_abort,
   input wire logic conv_done,
   input wire logic [RES_W-1:0] conv_data,
   output logic conversion_end_event,
   output logic conversion_status_flag
);
   typedef enum logic [2:0] {
      st_off = 3'b001,
      st_wait = 3'b010,
      st_conv = 3'b100
   } ats_state_type;

   ats_state_type state;
   logic enable, four_buf, select_mode, four_trig, chain, res_wr, sel_mem;
   logic [2:0] chan_sel, cur_slot, res_addr, next_chan, next_slot;
   logic [1:0] count, trig_src, lower_last, ostop, running;
   logic [3:0] match, acc_mask;
   logic trig_any, mode_wr;
   logic [15:0] compare [4];
   // Timer counts stay inside the timers; only their match pulses and run flags are used
   logic [RES_W-1:0] res_data, mem_q;
   logic [DATA_W-1:0] reg_q, next_rdata;

   assign mode_wr = bus_wr && (bus_addr == OFS_CONVERTER_MODE_REG0 || bus_addr == OFS_CONVERTER_MODE_REG1);

   // Converter mode registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         enable <= 1'b0;
         four_buf <= 1'b0;
         select_mode <= 1'b0;
         chan_sel <= CHAN_RST;
         four_trig <= 1'b0;
      end else if (bus_wr && bus_addr == OFS_CONVERTER_MODE_REG0) begin
         enable <= bus_wdata[M0_ENABLE_BIT];
         four_buf <= bus_wdata[M0_FOURBUF_BIT];
         select_mode <= bus_wdata[M0_SELECT_BIT];
         chan_sel <= bus_wdata[M0_CHAN_LSB +: 3];
      end else if (bus_wr && bus_addr == OFS_CONVERTER_MODE_REG1) begin
         four_trig <= bus_wdata[M1_FOURTRIG_BIT];
      end
   end

   // Timers and their compare registers, two compare units per timer
   generate
      for (genvar g = 0; g < 2; g++) begin : g_timer
         localparam logic [7:0] A_OFS = 8'(OFS_TIMER_CONTROL_REG_A + OFS_TIMER_STRIDE * g);
         localparam logic [7:0] B_OFS = 8'(OFS_TIMER_CONTROL_REG_B + OFS_TIMER_STRIDE * g);
         localparam logic [7:0] C0_OFS = 8'(OFS_COMPARE_REG_BASE + 8 * g);
         localparam logic [7:0] C1_OFS = 8'(OFS_COMPARE_REG_BASE + 8 * g + 4);

         // Overflow-stop and compare values
         always_ff @(posedge mclk) begin
            if (reset) begin
               ostop[g] <= 1'b0;
               compare[2*g] <= COMPARE_RST;
               compare[2*g+1] <= COMPARE_RST;
            end else if (bus_wr && bus_addr == B_OFS) begin
               ostop[g] <= bus_wdata[TC_B_OSTOP_BIT];
            end else if (bus_wr && bus_addr == C0_OFS) begin
               compare[2*g] <= bus_wdata;
            end else if (bus_wr && bus_addr == C1_OFS) begin
               compare[2*g+1] <= bus_wdata;
            end
         end

         ats_timer u_timer (
            .mclk(mclk),
            .reset(reset),
            .enable_wr(bus_wr && bus_addr == A_OFS), // RL2 RL6
            .enable_val(bus_wdata[TC_A_ENABLE_BIT]),
            .overflow_stop(ostop[g]),
            .compare_a(compare[2*g]),
            .compare_b(compare[2*g+1]),
            .running(running[g]),
            .count(),
            .match_a(match[2*g]),
            .match_b(match[2*g+1])
         );
      end
   endgenerate

   // One-trigger modes listen to match 00 only; simultaneous triggers go to the lowest
   assign acc_mask = four_trig ? match : {3'h0, match[0]}; // RL5 RL8 RL16
   assign lower_last = chan_sel[2] ? LAST_LOWER : chan_sel[1:0]; // RL14

   // Channel and result slot for the trigger now present
   always_comb begin
      trig_any = |acc_mask; // RL10
      trig_src = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (acc_mask[i]) begin
            trig_src = 2'(i);
         end
      end
      if (select_mode) begin
         next_chan = {1'b0, chan_sel[1:0]}; // RL4
         if (four_buf) begin
            next_slot = four_trig ? {1'b0, trig_src} : {1'b0, count}; // RL11 RL13
         end else begin
            next_slot = next_chan; // RL5 RL8
         end
      end else begin
         next_chan = four_trig ? {1'b0, trig_src} : {1'b0, count}; // RL16 RL19
         next_slot = next_chan; // RL14
      end
   end

   // Sequencer: trigger standby, conversion, upper-channel chaining
   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= st_off;
         count <= 2'h0;
         chain <= 1'b0;
         cur_slot <= 3'h0;
         conv_chan <= 3'h0;
         conv_start <= 1'b0;
         conv_abort <= 1'b0;
         conversion_end_event <= 1'b0;
         conversion_status_flag <= 1'b0;
         res_wr <= 1'b0;
         res_addr <= 3'h0;
         res_data <= '0;
      end else begin
         conv_start <= 1'b0;
         conv_abort <= 1'b0;
         conversion_end_event <= 1'b0;
         res_wr <= 1'b0;
         if (!enable) begin
            conv_abort <= (state == st_conv); // RL22 RL7
            state <= st_off;
            count <= 2'h0; // RL25
            chain <= 1'b0;
            conversion_status_flag <= 1'b0;
         end else if (mode_wr) begin
            conv_abort <= (state == st_conv); // RL23
            state <= st_wait;
            count <= 2'h0; // RL25
            chain <= 1'b0;
            conversion_status_flag <= 1'b0;
         end else begin
            unique case (state)
               st_off: begin
                  state <= st_wait; // RL21
               end
               st_wait: begin
                  if (trig_any) begin
                     conv_start <= 1'b1; // RL9 RL17 RL20
                     conv_chan <= next_chan;
                     cur_slot <= next_slot;
                     conversion_status_flag <= 1'b1; // RL9
                     state <= st_conv;
                  end
               end
               st_conv: begin
                  if (conv_done) begin
                     res_wr <= 1'b1;
                     res_addr <= cur_slot;
                     res_data <= conv_data;
                     if (chain) begin
                        if (conv_chan == chan_sel) begin
                           conversion_end_event <= 1'b1; // RL15
                           conversion_status_flag <= 1'b0;
                           chain <= 1'b0;
                           state <= st_wait;
                        end else begin
                           conv_start <= 1'b1; // RL15
                           conv_chan <= conv_chan + 3'h1;
                           cur_slot <= cur_slot + 3'h1;
                        end
                     end else if (!select_mode && count == lower_last && chan_sel[2]) begin
                        conv_start <= 1'b1; // RL15
                        conv_chan <= FIRST_UPPER;
                        cur_slot <= FIRST_UPPER;
                        chain <= 1'b1;
                        count <= 2'h0;
                     end else if ((!select_mode && count != lower_last) || (select_mode && four_buf && count != 2'h3)) begin
                        count <= count + 2'h1; // RL12 RL18
                        state <= st_wait;
                     end else begin
                        conversion_end_event <= 1'b1; // RL5 RL8 RL11 RL16
                        conversion_status_flag <= 1'b0;
                        count <= 2'h0; // RL25
                        state <= st_wait; // RL6 RL7 RL21
                     end
                  end else if (trig_any && !chain) begin
                     conv_abort <= 1'b1;
                     conv_start <= 1'b1;
                     conv_chan <= next_chan;
                     cur_slot <= next_slot;
                  end
               end
            endcase
         end
      end
   end

   ats_result_mem u_results (
      .mclk(mclk),
      .reset(reset),
      .wr_en(res_wr),
      .wr_addr(res_addr),
      .wr_data(res_data),
      .rd_addr(bus_addr[4:2]),
      .rd_data(mem_q)
   );

   // Register read mux; unmapped offsets read zero
   always_comb begin
      next_rdata = '0;
      if (bus_addr == OFS_CONVERTER_MODE_REG0) begin
         next_rdata[M0_ENABLE_BIT] = enable;
         next_rdata[M0_STATUS_BIT] = conversion_status_flag;
         next_rdata[M0_FOURBUF_BIT] = four_buf;
         next_rdata[M0_SELECT_BIT] = select_mode;
         next_rdata[M0_CHAN_LSB +: 3] = chan_sel;
      end else if (bus_addr == OFS_CONVERTER_MODE_REG1) begin
         next_rdata[M1_FOURTRIG_BIT] = four_trig;
      end
      for (int t = 0; t < 2; t++) begin
         if (bus_addr == 8'(OFS_TIMER_CONTROL_REG_A + OFS_TIMER_STRIDE * t)) begin
            next_rdata[TC_A_ENABLE_BIT] = running[t];
         end
         if (bus_addr == 8'(OFS_TIMER_CONTROL_REG_B + OFS_TIMER_STRIDE * t)) begin
            next_rdata[TC_B_OSTOP_BIT] = ostop[t];
         end
      end
      for (int k = 0; k < 4; k++) begin
         if (bus_addr == 8'(OFS_COMPARE_REG_BASE + 4 * k)) begin
            next_rdata = compare[k];
         end
      end
   end

   // Read data stand for the single cycle after the strobe
   always_ff @(posedge mclk) begin
      if (reset) begin
         reg_q <= '0;
         sel_mem <= 1'b0;
      end else begin
         reg_q <= bus_rd ? next_rdata : '0;
         sel_mem <= bus_rd && bus_addr >= OFS_CONV_RESULT_REG_BASE && bus_addr < OFS_CONV_RESULT_REG_END
                    && bus_addr[1:0] == 2'h0;
      end
   end

   assign bus_rdata = sel_mem ? {{(DATA_W-RES_W){1'b0}}, mem_q} : reg_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   a_disabled_quiet: assert property (!enable |=> !conv_start && !res_wr) // RL22
      else $error("conversion activity while converter disabled");
   a_mode_write_abort: assert property (mode_wr && enable && state == st_conv |=> conv_abort && !res_wr ##1 !res_wr) // RL23
      else $error("mode write did not abort conversion");
   a_start_sets_flag: assert property (conv_start |-> conversion_status_flag) // RL9
      else $error("conversion started without status flag");
   a_end_clears_flag: assert property (conversion_end_event |-> !conversion_status_flag && res_wr) // RL5
      else $error("end event without result write or flag clear");
   a_fourbuf_end_slot: assert property (conversion_end_event && select_mode && four_buf && !four_trig |-> res_addr == 3'h3) // RL11
      else $error("four-buffer end not after fourth result");
   a_onebuf_slot: assert property (res_wr && select_mode && !four_buf |-> res_addr == {1'b0, chan_sel[1:0]}) // RL4
      else $error("one-buffer result went to wrong register");
   a_source_slot: assert property (conv_start && select_mode && four_buf && four_trig && $past(state) == st_wait
      |-> cur_slot == {1'b0, $past(trig_src)}) // RL13
      else $error("four-trigger slot does not follow source");
   a_trigger_taken: assert property (state == st_wait && enable && !mode_wr && trig_any |=> conv_start) // RL10
      else $error("accepted trigger did not start conversion");
   a_single_source: assert property (!four_trig && state == st_wait && enable && !mode_wr && !match[0]
      |=> !conv_start) // RL16
      else $error("one-trigger mode started on another source");
   a_chain_next: assert property (state == st_conv && chain && conv_done && enable && !mode_wr && conv_chan != chan_sel
      |=> conv_start && conv_chan == 3'($past(conv_chan) + 3'h1)) // RL15
      else $error("upper channel not converted back to back");

   c_fourbuf_end: cover property (conversion_end_event && select_mode && four_buf);
   c_scan_chain: cover property (conv_start && chain ##[1:200] conversion_end_event);
   c_abort_seen: cover property (conv_abort && !enable);
   c_scan_restart: cover property (conversion_end_event && !select_mode ##[1:300] conv_start);
endmodule : ats_sequencer

`default_nettype wire

// >>> ats_conv_model.sv
/*
 * Behavioural converter core on the far side of the sequencer.
 * Assumes one clock, start and abort pulses from the sequencer.
 */
`default_nettype none

module ats_conv_model import ats_pkg::*; #(
   parameter int LAT = 6
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic conv_start,
   input wire logic [2:0] conv_chan,
   input wire logic conv_abort,
   output logic conv_done,
   output logic [RES_W-1:0] conv_data,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   int left;
   logic [6:0] seq;
   logic [RES_W-1:0] last;

   // One job at a time; a new start replaces the running one
   always_ff @(posedge mclk) begin
      conv_done <= 1'b0;
      if (reset) begin
         busy <= 1'b0;
         left <= 0;
         seq <= 7'h00;
         last <= '0;
      end else if (conv_start) begin
         busy <= 1'b1;
         left <= LAT;
         last <= {conv_chan, seq};
         seq <= seq + 7'h01;
      end else if (conv_abort) begin
         busy <= 1'b0;
      end else if (busy && left == 1) begin
         busy <= 1'b0;
         conv_done <= 1'b1;
      end else if (busy) begin
         left <= left - 1;
      end
   end

   // Result only valid with done; inverted otherwise
   assign conv_data = conv_done ? last : ~last;
endmodule // ats_conv_model

`default_nettype wire

// >>> tb.sv
/*
 * Self-checking bench for the timer-triggered conversion sequencer.
 * Assumes the converter model answers after a fixed latency.
 */
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module tb import ats_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [ADDR_W-1:0] bus_addr = '0;
   logic [DATA_W-1:0] bus_wdata = '0;
   logic [DATA_W-1:0] bus_rdata, rd_val;
   logic conv_start, conv_abort, conv_done, busy, conversion_end_event, conversion_status_flag;
   logic [2:0] conv_chan;
   logic [RES_W-1:0] conv_data;
   logic [RES_W-1:0] dq[$];
   int err_total = 0;
   int total_checks = 0;
   int n_start = 0;
   int n_end = 0;
   int n_abort = 0;

   always #12.5 mclk = ~mclk;

   ats_sequencer dut_u (.mclk, .reset, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
      .conv_start, .conv_chan, .conv_abort, .conv_done, .conv_data, .conversion_end_event,
      .conversion_status_flag);
   ats_conv_model #(.LAT(6)) conv_u (.mclk, .reset, .conv_start, .conv_chan, .conv_abort,
      .conv_done, .conv_data, .busy);

   // Count pulses mid-cycle and record finished results
   always @(negedge mclk) begin
      if (conv_start) n_start++;
      if (conversion_end_event) n_end++;
      if (conv_abort) n_abort++;
      if (conv_done) dq.push_back(conv_data);
   end

   task automatic wrap_up;
      if (err_total == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge mclk);
      bus_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge mclk);
      bus_rd <= 1'b0;
      @(negedge mclk);
      rd_val = bus_rdata;
   endtask

   task automatic res(input int n, input logic [RES_W-1:0] e);
      rd(OFS_CONV_RESULT_REG_BASE + 8'(4 * n));
      `CHK("result", 16'(e), rd_val)
   endtask

   // Wait until the converter has been idle for a few cycles
   task automatic settle;
      int q;
      q = 0;
      for (int i = 0; i < 300 && q < 4; i++) begin
         @(negedge mclk);
         q = busy ? 0 : q + 1;
      end
   endtask

   task automatic mode(input logic [15:0] m0, input logic [15:0] m1);
      wr(OFS_CONVERTER_MODE_REG1, m1);
      wr(OFS_CONVERTER_MODE_REG0, m0);
      dq.delete();
   endtask

   // One match pulse from source s, then stop its timer
   task automatic fire(input int s);
      logic [7:0] ta;
      logic [7:0] ca;
      ta = OFS_TIMER_CONTROL_REG_A + 8'(s / 2) * OFS_TIMER_STRIDE;
      ca = OFS_COMPARE_REG_BASE + 8'(4 * s);
      wr(ca, 16'h0004);
      wr(ta, 16'h0001);
      repeat (10) @(posedge mclk);
      wr(ta, 16'h0000);
      wr(ca, 16'hffff);
      settle();
   endtask

   task automatic t_sel1;
      int s0;
      mode(16'h0012, 16'h0000);
      fire(0);
      `CHK("starts", 0, n_start)
      mode(16'h0092, 16'h0000);
      s0 = n_end;
      fire(0);
      fire(1);
      `CHK("ends", s0 + 1, n_end)
      `CHK("chan", 3'h2, conv_chan)
      `CHK("flag", 1'b0, conversion_status_flag)
      `CHK("dchan", 3'h2, dq[0][9:7])
      res(2, dq[0]);
   endtask

   task automatic t_sel4trig;
      int s0;
      mode(16'h0091, 16'h0001);
      s0 = n_end;
      fire(3);
      fire(3);
      fire(0);
      `CHK("ends", s0 + 3, n_end)
      res(1, dq[2]);
   endtask

   task automatic t_buf4;
      int s0;
      mode(16'h00b3, 16'h0000);
      s0 = n_end;
      repeat (3) fire(0);
      `CHK("ends", s0, n_end)
      `CHK("flag", 1'b1, conversion_status_flag)
      fire(0);
      `CHK("ends", s0 + 1, n_end)
      `CHK("flag", 1'b0, conversion_status_flag)
      for (int k = 0; k < 4; k++) res(k, dq[k]);
   endtask

   task automatic t_buf4trig4;
      int o[4] = '{3, 1, 0, 2};
      int s0;
      mode(16'h00b0, 16'h0001);
      s0 = n_end;
      for (int i = 0; i < 4; i++) fire(o[i]);
      `CHK("ends", s0 + 1, n_end)
      for (int i = 0; i < 4; i++) res(o[i], dq[i]);
   endtask

   task automatic t_scan1;
      int s0;
      int e0;
      mode(16'h0085, 16'h0000);
      s0 = n_start;
      e0 = n_end;
      repeat (4) fire(0);
      `CHK("starts", s0 + 6, n_start)
      `CHK("ends", e0 + 1, n_end)
      for (int k = 0; k < 6; k++) `CHK("dchan", 3'(k), dq[k][9:7])
      for (int k = 0; k < 6; k++) res(k, dq[k]);
      fire(0);
      `CHK("chan", 3'h0, conv_chan)
      `CHK("starts", s0 + 7, n_start)
   endtask

   task automatic t_scan4;
      int o[4] = '{2, 0, 3, 1};
      int s0;
      mode(16'h0083, 16'h0001);
      s0 = n_end;
      for (int i = 0; i < 4; i++) fire(o[i]);
      `CHK("ends", s0 + 1, n_end)
      for (int i = 0; i < 4; i++) `CHK("dchan", 3'(o[i]), dq[i][9:7])
      for (int i = 0; i < 4; i++) res(o[i], dq[i]);
   endtask

   // Start a conversion of channel 3, then write a mode register mid-way
   task automatic abort_by(input logic [7:0] a, input logic [15:0] d);
      int s;
      mode(16'h0093, 16'h0000);
      s = n_start;
      wr(OFS_COMPARE_REG_BASE, 16'h0004);
      wr(OFS_TIMER_CONTROL_REG_A, 16'h0001);
      for (int i = 0; i < 20 && n_start == s; i++) @(negedge mclk);
      wr(a, d);
      wr(OFS_TIMER_CONTROL_REG_A, 16'h0000);
      settle();
   endtask

   task automatic t_abort;
      logic [15:0] keep;
      int a0;
      rd(OFS_CONV_RESULT_REG_BASE + 8'h0c);
      keep = rd_val;
      a0 = n_abort;
      abort_by(OFS_CONVERTER_MODE_REG0, 16'h0013);
      `CHK("aborts", a0 + 1, n_abort)
      `CHK("flag", 1'b0, conversion_status_flag)
      res(3, keep[RES_W-1:0]);
      abort_by(OFS_CONVERTER_MODE_REG1, 16'h0000);
      `CHK("aborts", a0 + 2, n_abort)
      res(3, keep[RES_W-1:0]);
   endtask

   // One-shot timer: one match per run, stops at overflow
   task automatic t_oneshot;
      int s0;
      mode(16'h0090, 16'h0000);
      wr(OFS_TIMER_CONTROL_REG_B, 16'h0001);
      s0 = n_start;
      wr(OFS_TIMER_CONTROL_REG_A, 16'h0001);
      repeat (66000) @(posedge mclk);
      `CHK("starts", s0 + 1, n_start)
      rd(OFS_TIMER_CONTROL_REG_A);
      `CHK("running", 1'b0, rd_val[0])
      wr(OFS_TIMER_CONTROL_REG_A, 16'h0001);
      repeat (12) @(posedge mclk);
      settle();
      `CHK("starts", s0 + 2, n_start)
   endtask

   // Watchdog for a hung sequence
   initial begin
      repeat (95000) @(posedge mclk);
      err_total++;
      wrap_up();
   end

   initial begin
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      for (int s = 0; s < 4; s++) wr(OFS_COMPARE_REG_BASE + 8'(4 * s), 16'hffff);
      t_sel1();
      t_sel4trig();
      t_buf4();
      t_buf4trig4();
      t_scan1();
      t_scan4();
      t_abort();
      t_oneshot();
      wrap_up();
   end
endmodule // tb

`default_nettype wire
